/* include/cdmd_defs.svh */
/*
 * constants of the data move decoder: instruction fields, alignment masks,
 * reset values and the minimum timing figure.
 * assumes 16-bit instruction words and 32-bit general registers.
 */
`ifndef CDMD_DEFS_SVH
`define CDMD_DEFS_SVH

// instruction word fields
`define CDMD_OPC_HI 15
`define CDMD_OPC_LO 12
`define CDMD_FN_HI 11
`define CDMD_FN_LO 8
`define CDMD_FM_HI 7
`define CDMD_FM_LO 4
`define CDMD_D4_HI 3
`define CDMD_D4_LO 0
`define CDMD_D8_HI 7
`define CDMD_D8_LO 0

// register index of gpr_zero
`define CDMD_GPR_ZERO 4'h0

// reset values
`define CDMD_RST_WORD 32'h0000_0000
`define CDMD_RST_IDX 4'h0

// address masks for natural alignment
`define CDMD_ALIGN_WORD 32'hffff_fffe
`define CDMD_ALIGN_LONG 32'hffff_fffc

// least execution cycles of every move with no wait states
`define CDMD_MIN_EXEC_CYCLES 1

`endif

/* include/cdmd_pkg.sv */
/*
 * types of the data move decoder: operation kinds, operand sizes,
 * execute state and the decoded instruction record.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cdmd_pkg;

	typedef enum logic [1:0] {
		CDMD_SZ_BYTE = 2'b00,
		CDMD_SZ_WORD = 2'b01,
		CDMD_SZ_LONG = 2'b10
	} cdmd_size_t;

	typedef enum logic [3:0] {
		CDMD_K_ILLEGAL = 4'b0000,
		CDMD_K_MV_IMM = 4'b0001,
		CDMD_K_MV_REG = 4'b0010,
		CDMD_K_LD_PC = 4'b0011,
		CDMD_K_ST_IND = 4'b0100,
		CDMD_K_LD_IND = 4'b0101,
		CDMD_K_ST_PRE = 4'b0110,
		CDMD_K_LD_POST = 4'b0111,
		CDMD_K_ST_DSP0 = 4'b1000,
		CDMD_K_ST_DSPL = 4'b1001,
		CDMD_K_LD_DSP0 = 4'b1010,
		CDMD_K_LD_DSPL = 4'b1011,
		CDMD_K_ST_IDX = 4'b1100
	} cdmd_kind_t;

	typedef enum logic {
		CDMD_EX_IDLE = 1'b0,
		CDMD_EX_BUSY = 1'b1
	} cdmd_ex_state_t;

	typedef struct packed {
		cdmd_kind_t kind;
		cdmd_size_t size;
		logic [3:0] dst;
		logic [7:0] disp;
	} cdmd_dec_t;

endpackage

/* rtl/cdmd_gpr_file.sv */
/*
 * sixteen 32-bit general registers with three registered read ports
 * (field n, field m, gpr_zero) and two write ports with write bypass.
 * assumes port a carries the younger write, so it wins on a clash.
 */
`timescale 1ns/1ps
`include "cdmd_defs.svh"

module cdmd_gpr_file (
	input wire logic clk, // core clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic rd_en, // capture read ports
	input wire logic [3:0] rd_n_idx, // read index, n field
	input wire logic [3:0] rd_m_idx, // read index, m field
	output logic [31:0] rd_n_q, // registered n operand
	output logic [31:0] rd_m_q, // registered m operand
	output logic [31:0] rd_z_q, // registered gpr_zero operand
	input wire logic wa_en, // write port a enable
	input wire logic [3:0] wa_idx, // write port a index
	input wire logic [31:0] wa_data, // write port a data
	input wire logic wb_en, // write port b enable
	input wire logic [3:0] wb_idx, // write port b index
	input wire logic [31:0] wb_data // write port b data
);

	logic [31:0] mem_reg [16];
	logic [31:0] n_next, m_next, z_next;

	function automatic logic [31:0] rd_byp(input logic [3:0] idx,
			input logic [31:0] cur);
		logic [31:0] v;
		v = cur;
		if (wb_en && wb_idx == idx) begin
			v = wb_data;
		end
		if (wa_en && wa_idx == idx) begin
			v = wa_data;
		end
		return v;
	endfunction

	always_comb begin
		n_next = rd_n_q;
		m_next = rd_m_q;
		z_next = rd_z_q;
		if (rd_en) begin
			n_next = rd_byp(rd_n_idx, mem_reg[rd_n_idx]);
			m_next = rd_byp(rd_m_idx, mem_reg[rd_m_idx]);
			z_next = rd_byp(`CDMD_GPR_ZERO, mem_reg[`CDMD_GPR_ZERO]);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_n_q <= `CDMD_RST_WORD;
			rd_m_q <= `CDMD_RST_WORD;
			rd_z_q <= `CDMD_RST_WORD;
			for (int i = 0; i < 16; i++) begin
				mem_reg[i] <= `CDMD_RST_WORD;
			end
		end else if (ce) begin
			rd_n_q <= n_next;
			rd_m_q <= m_next;
			rd_z_q <= z_next;
			// younger write on port a overrides port b
			if (wb_en) begin
				mem_reg[wb_idx] <= wb_data;
			end
			if (wa_en) begin
				mem_reg[wa_idx] <= wa_data;
			end
		end
	end

endmodule

/* rtl/cdmd_core.sv */
/*
 * decode and execute of the register and load/store move group.
 * takes instruction words from the fetch path, issues data accesses,
 * writes the general registers; read data return one cycle after ack.
 * assumes fetch and data share one memory path, signalled by fetch_busy.
 */
// Summary of operation
// RQ1: register indices come from 4-bit fields
// RQ2: one cycle per move without wait states
// RQ3: fetch contention delays the data access
// RQ4: stall consumer of a pending load result
// RQ5: moves never touch the test flag
// RQ6: immediate sign-extended into destination
// RQ7: PC-relative word load, disp times two
// RQ8: PC-relative longword load, disp times four
// RQ9: register to register full copy
// RQ10: store source at destination register address
// RQ11: load via source register address, sign-extend
// RQ12: pre-decrement destination, then store
// RQ13: load, then post-increment source register
// RQ14: store gpr_zero at scaled displacement address
// RQ15: store longword at disp times four
// RQ16: load byte/word at displacement into gpr_zero
// RQ17: load longword at disp times four
// RQ18: store at gpr_zero plus destination register
// RQ19: displacement scaled by operand size
// RQ20: displacements are unsigned, zero-extended
// RQ21: aligned addresses, PC base low bits cleared
// RQ22: undefined patterns go to illegal handling
`timescale 1ns/1ps
`include "cdmd_defs.svh"

module cdmd_core (
	input wire logic clk, // core clock, 100 MHz
	input wire logic reset_n, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic instr_valid, // instruction word offered
	input wire logic [15:0] instr_word, // instruction word
	input wire logic [31:0] instr_pc, // pc base for this instruction
	output logic instr_ready, // instruction taken when valid too
	input wire logic fetch_busy, // fetch owns the memory path now
	output logic data_req, // data access request
	output logic data_we, // 1 write, 0 read
	output logic [1:0] data_size, // operand_size of the access
	output logic [31:0] data_addr, // byte address, naturally aligned
	output logic [31:0] data_wdata, // write data, low justified
	input wire logic data_ack, // request accepted this cycle
	input wire logic [31:0] data_rdata, // read data, cycle after ack
	output logic illegal_instr, // pulse, undefined pattern taken
	output logic sr_t_we // test flag write, never asserted
);

	cdmd_pkg::cdmd_ex_state_t st_reg, st_next;
	cdmd_pkg::cdmd_dec_t ex_reg, ex_next;
	logic [31:0] pc_reg, pc_next;
	logic ill_reg, ill_next;
	logic ld_reg, ld_next;
	logic [3:0] ld_dst_reg, ld_dst_next;
	cdmd_pkg::cdmd_size_t ld_sz_reg, ld_sz_next;
	logic [31:0] rn_q, rm_q, rz_q;
	logic take, ex_done, is_mem, is_load, hazard;
	logic wa_en, wb_en;
	logic [3:0] wa_idx;
	logic [31:0] wa_data, wb_data, addr_raw;
	cdmd_pkg::cdmd_dec_t dec_in;

	////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] sext(input logic [31:0] v,
			input cdmd_pkg::cdmd_size_t sz);
		logic [31:0] r;
		r = v;
		case (sz)
			cdmd_pkg::CDMD_SZ_BYTE: r = {{24{v[7]}}, v[7:0]};
			cdmd_pkg::CDMD_SZ_WORD: r = {{16{v[15]}}, v[15:0]};
			default: r = v;
		endcase
		return r;
	endfunction

	// RQ19: scale by size
	// RQ20: unsigned displacement
	function automatic logic [31:0] scaled(input logic [7:0] d,
			input cdmd_pkg::cdmd_size_t sz);
		logic [31:0] r;
		r = {24'h00_0000, d};
		case (sz)
			cdmd_pkg::CDMD_SZ_WORD: r = {r[30:0], 1'b0};
			cdmd_pkg::CDMD_SZ_LONG: r = {r[29:0], 2'b00};
			default: r = {24'h00_0000, d};
		endcase
		return r;
	endfunction

	// RQ21: natural alignment
	function automatic logic [31:0] align(input logic [31:0] a,
			input cdmd_pkg::cdmd_size_t sz);
		logic [31:0] r;
		r = a;
		case (sz)
			cdmd_pkg::CDMD_SZ_WORD: r = a & `CDMD_ALIGN_WORD;
			cdmd_pkg::CDMD_SZ_LONG: r = a & `CDMD_ALIGN_LONG;
			default: r = a;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// decode

	function automatic cdmd_pkg::cdmd_dec_t decode(input logic [15:0] w);
		cdmd_pkg::cdmd_dec_t d;
		d.kind = cdmd_pkg::CDMD_K_ILLEGAL;
		d.size = cdmd_pkg::cdmd_size_t'(w[1:0]);
		// RQ1: 4-bit register fields
		d.dst = w[`CDMD_FN_HI:`CDMD_FN_LO];
		d.disp = {4'h0, w[`CDMD_D4_HI:`CDMD_D4_LO]};
		casez (w)
			// RQ6: immediate move
			16'he???: begin
				d.kind = cdmd_pkg::CDMD_K_MV_IMM;
				d.disp = w[`CDMD_D8_HI:`CDMD_D8_LO];
			end
			// RQ7: pc-relative word
			16'h9???: begin
				d.kind = cdmd_pkg::CDMD_K_LD_PC;
				d.size = cdmd_pkg::CDMD_SZ_WORD;
				d.disp = w[`CDMD_D8_HI:`CDMD_D8_LO];
			end
			// RQ8: pc-relative longword
			16'hd???: begin
				d.kind = cdmd_pkg::CDMD_K_LD_PC;
				d.size = cdmd_pkg::CDMD_SZ_LONG;
				d.disp = w[`CDMD_D8_HI:`CDMD_D8_LO];
			end
			// RQ9: register copy
			16'b0110_????_????_0011: d.kind = cdmd_pkg::CDMD_K_MV_REG;
			16'b0010_????_????_00??: d.kind = cdmd_pkg::CDMD_K_ST_IND;
			16'b0110_????_????_00??: d.kind = cdmd_pkg::CDMD_K_LD_IND;
			16'b0010_????_????_01??: d.kind = cdmd_pkg::CDMD_K_ST_PRE;
			16'b0110_????_????_01??: d.kind = cdmd_pkg::CDMD_K_LD_POST;
			16'b1000_000?_????_????: d.kind = cdmd_pkg::CDMD_K_ST_DSP0;
			16'b1000_010?_????_????: begin
				d.kind = cdmd_pkg::CDMD_K_LD_DSP0;
				d.dst = `CDMD_GPR_ZERO;
			end
			16'h1???: begin
				d.kind = cdmd_pkg::CDMD_K_ST_DSPL;
				d.size = cdmd_pkg::CDMD_SZ_LONG;
			end
			16'h5???: begin
				d.kind = cdmd_pkg::CDMD_K_LD_DSPL;
				d.size = cdmd_pkg::CDMD_SZ_LONG;
			end
			16'b0000_????_????_010?: d.kind = cdmd_pkg::CDMD_K_ST_IDX;
			default: d.kind = cdmd_pkg::CDMD_K_ILLEGAL;
		endcase
		if (w[15:12] == 4'h8) begin
			d.size = cdmd_pkg::cdmd_size_t'({1'b0, w[8]});
		end
		// RQ22: size code 11 of the nibble forms is undefined
		if (d.size == 2'b11 && d.kind != cdmd_pkg::CDMD_K_MV_IMM &&
				d.kind != cdmd_pkg::CDMD_K_LD_PC &&
				d.kind != cdmd_pkg::CDMD_K_MV_REG) begin
			d.kind = cdmd_pkg::CDMD_K_ILLEGAL;
		end
		return d;
	endfunction

	assign dec_in = decode(instr_word);

	////////////////////////////////////////////////////////////////////
	// execute

	always_comb begin
		is_load = 1'b0;
		is_mem = 1'b1;
		addr_raw = rm_q;
		data_we = 1'b0;
		data_wdata = rm_q;
		wa_idx = ex_reg.dst;
		wa_data = rm_q;
		wa_en = 1'b0;
		case (ex_reg.kind)
			cdmd_pkg::CDMD_K_MV_IMM: begin
				is_mem = 1'b0;
				wa_en = 1'b1;
				wa_data = sext({24'h00_0000, ex_reg.disp},
					cdmd_pkg::CDMD_SZ_BYTE);
			end
			cdmd_pkg::CDMD_K_MV_REG: begin
				is_mem = 1'b0;
				wa_en = 1'b1;
			end
			// RQ21: pc base cleared for longword
			cdmd_pkg::CDMD_K_LD_PC: begin
				is_load = 1'b1;
				addr_raw = align(pc_reg, ex_reg.size) +
					scaled(ex_reg.disp, ex_reg.size);
			end
			// RQ10: indirect store
			cdmd_pkg::CDMD_K_ST_IND: begin
				data_we = 1'b1;
				addr_raw = rn_q;
			end
			// RQ11: indirect load
			cdmd_pkg::CDMD_K_LD_IND: is_load = 1'b1;
			// RQ12: decrement then store
			cdmd_pkg::CDMD_K_ST_PRE: begin
				data_we = 1'b1;
				addr_raw = rn_q - scaled(8'h01, ex_reg.size);
				wa_en = 1'b1;
				wa_data = addr_raw;
			end
			// RQ13: source register stepped after load
			cdmd_pkg::CDMD_K_LD_POST: begin
				is_load = 1'b1;
				wa_en = 1'b1;
				wa_idx = instr_m_idx(ex_reg);
				wa_data = rm_q + scaled(8'h01, ex_reg.size);
			end
			// RQ14: gpr_zero stored at displacement
			cdmd_pkg::CDMD_K_ST_DSP0: begin
				data_we = 1'b1;
				data_wdata = rz_q;
				addr_raw = rm_q + scaled(ex_reg.disp, ex_reg.size);
			end
			// RQ15: longword displacement store
			cdmd_pkg::CDMD_K_ST_DSPL: begin
				data_we = 1'b1;
				addr_raw = rn_q + scaled(ex_reg.disp, ex_reg.size);
			end
			// RQ16: displacement load to gpr_zero
			// RQ17: longword displacement load
			cdmd_pkg::CDMD_K_LD_DSP0, cdmd_pkg::CDMD_K_LD_DSPL: begin
				is_load = 1'b1;
				addr_raw = rm_q + scaled(ex_reg.disp, ex_reg.size);
			end
			// RQ18: indexed store
			cdmd_pkg::CDMD_K_ST_IDX: begin
				data_we = 1'b1;
				addr_raw = rz_q + rn_q;
			end
			default: is_mem = 1'b0;
		endcase
	end

	// m index lives in the displacement slot's upper nibble record
	function automatic logic [3:0] instr_m_idx(
			input cdmd_pkg::cdmd_dec_t d);
		return d.disp[7:4];
	endfunction

	assign data_addr = align(addr_raw, ex_reg.size);
	assign data_size = ex_reg.size;
	// RQ3: fetch owns the path, data waits
	// no request while frozen, an ack then would be lost
	assign data_req = (st_reg == cdmd_pkg::CDMD_EX_BUSY) && is_mem &&
		!fetch_busy && ce;
	// RQ2: done in the first cycle unless waited
	assign ex_done = (st_reg == cdmd_pkg::CDMD_EX_IDLE) || !is_mem ||
		(data_req && data_ack);

	// RQ4: consumer held while load data pending
	assign hazard = (st_reg == cdmd_pkg::CDMD_EX_BUSY) && is_load &&
		(ex_reg.dst == instr_word[`CDMD_FN_HI:`CDMD_FN_LO] ||
		ex_reg.dst == instr_word[`CDMD_FM_HI:`CDMD_FM_LO] ||
		ex_reg.dst == `CDMD_GPR_ZERO);
	assign instr_ready = ce && reset_n && ex_done && !hazard;
	assign take = instr_ready && instr_valid;

	////////////////////////////////////////////////////////////////////
	// pipeline state

	always_comb begin
		st_next = st_reg;
		ex_next = ex_reg;
		pc_next = pc_reg;
		ill_next = 1'b0;
		ld_next = 1'b0;
		ld_dst_next = ld_dst_reg;
		ld_sz_next = ld_sz_reg;
		if (st_reg == cdmd_pkg::CDMD_EX_BUSY && is_load && ex_done) begin
			ld_next = 1'b1;
			ld_dst_next = ex_reg.dst;
			ld_sz_next = ex_reg.size;
		end
		if (ex_done) begin
			st_next = cdmd_pkg::CDMD_EX_IDLE;
		end
		if (take) begin
			ex_next = dec_in;
			if (dec_in.kind == cdmd_pkg::CDMD_K_LD_POST) begin
				ex_next.disp = {instr_word[`CDMD_FM_HI:`CDMD_FM_LO],
					4'h0};
			end
			pc_next = instr_pc;
			// RQ22: not executed, flagged instead
			if (dec_in.kind == cdmd_pkg::CDMD_K_ILLEGAL) begin
				ill_next = 1'b1;
			end else begin
				st_next = cdmd_pkg::CDMD_EX_BUSY;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= cdmd_pkg::CDMD_EX_IDLE;
			ex_reg <= '0;
			pc_reg <= `CDMD_RST_WORD;
			ill_reg <= 1'b0;
			ld_reg <= 1'b0;
			ld_dst_reg <= `CDMD_RST_IDX;
			ld_sz_reg <= cdmd_pkg::CDMD_SZ_BYTE;
		end else if (ce) begin
			st_reg <= st_next;
			ex_reg <= ex_next;
			pc_reg <= pc_next;
			ill_reg <= ill_next;
			ld_reg <= ld_next;
			ld_dst_reg <= ld_dst_next;
			ld_sz_reg <= ld_sz_next;
		end
	end

	// RQ11: loaded byte and word sign-extended
	assign wb_data = sext(data_rdata, ld_sz_reg);
	assign wb_en = ld_reg && ce;
	assign illegal_instr = ill_reg;
	// RQ5: test flag left alone
	assign sr_t_we = 1'b0;

	////////////////////////////////////////////////////////////////////
	// general registers

	cdmd_gpr_file u_gpr (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.rd_en(take),
		.rd_n_idx(instr_word[`CDMD_FN_HI:`CDMD_FN_LO]),
		.rd_m_idx(instr_word[`CDMD_FM_HI:`CDMD_FM_LO]),
		.rd_n_q(rn_q),
		.rd_m_q(rm_q),
		.rd_z_q(rz_q),
		.wa_en(wa_en && ex_done && st_reg == cdmd_pkg::CDMD_EX_BUSY),
		.wa_idx(wa_idx),
		.wa_data(wa_data),
		.wb_en(wb_en),
		.wb_idx(ld_dst_reg),
		.wb_data(wb_data)
	);

endmodule

/* sim/cdmd_core_monitor.sv */
/*
 * concurrent checks on the ports of the data move core.
 * assumes one clock domain and reset_n synchronous, active low.
 */
`timescale 1ns/1ps

module cdmd_core_monitor (
	input wire logic clk, // core clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic instr_valid, // instruction offered
	input wire logic [15:0] instr_word, // instruction word
	input wire logic instr_ready, // instruction taken
	input wire logic fetch_busy, // fetch owns memory path
	input wire logic data_req, // data access request
	input wire logic data_we, // write strobe
	input wire logic [1:0] data_size, // operand size
	input wire logic [31:0] data_addr, // byte address
	input wire logic data_ack, // access accepted
	input wire logic illegal_instr, // undefined pattern pulse
	input wire logic sr_t_we // test flag write
);
	wire take = instr_valid && instr_ready && ce;
	wire nib_ok = !instr_word[3] && instr_word[1:0] != 2'h3;
	wire [3:0] top = instr_word[15:12];
	wire [1:0] word_sz = instr_word[1:0];

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	test_flag_quiet_a: assert property (!sr_t_we)
		else $error("test flag written by a move");
	fetch_block_a: assert property (fetch_busy |-> !data_req)
		else $error("data request during fetch");
	req_hold_a: assert property (data_req && !data_ack |=>
		fetch_busy || (data_req && $stable(data_addr) && $stable(data_size)))
		else $error("request not held until accepted");
	word_align_a: assert property (
		data_req && data_size == 2'h1 |-> !data_addr[0])
		else $error("word access misaligned");
	long_align_a: assert property (
		data_req && data_size == 2'h2 |-> data_addr[1:0] == 2'h0)
		else $error("longword access misaligned");
	illegal_once_a: assert property (illegal_instr |-> $past(take))
		else $error("illegal pulse without a taken word");
	imm_no_access_a: assert property (take && top == 4'he |=>
		!data_req && !illegal_instr)
		else $error("immediate move touched memory or flagged");
	store_issue_a: assert property (take && top == 4'h2 && nib_ok |=>
		fetch_busy || (data_req && data_we && data_size == $past(word_sz)))
		else $error("store not issued next cycle");
	load_issue_a: assert property (take && top == 4'h6 && nib_ok |=>
		fetch_busy || (data_req && !data_we && data_size == $past(word_sz)))
		else $error("load not issued next cycle");
	pc_long_a: assert property (take && top == 4'hd |=>
		fetch_busy || (data_req && !data_we && data_size == 2'h2))
		else $error("pc relative load not issued");

	cover property (take && top == 4'h2);
	cover property (data_req && !data_ack);
	cover property (illegal_instr);
	cover property (illegal_instr ##1 illegal_instr);
endmodule

bind cdmd_core cdmd_core_monitor i_cdmd_core_monitor (.clk, .reset_n, .ce,
	.instr_valid, .instr_word, .instr_ready, .fetch_busy, .data_req,
	.data_we, .data_size, .data_addr, .data_ack, .illegal_instr, .sr_t_we);

/* sim/cdmd_mem_model.sv */
/*
 * data memory on the far side: acks promptly or with random waits,
 * read data is a function of the address.
 * assumes inputs settled at the rising edge.
 */
`timescale 1ns/1ps

module cdmd_mem_model (
	input wire logic clk, // core clock
	input wire logic slow, // insert random wait states
	input wire logic data_req, // access request
	input wire logic data_we, // 1 write, 0 read
	input wire logic [31:0] data_addr, // byte address
	output logic data_ack, // access accepted
	output logic [31:0] data_rdata // read data, cycle after ack
);
	logic rd_hit;
	logic [31:0] rd_addr;

	initial begin
		data_ack = 1'b0;
		data_rdata = 32'h0;
	end

	always @(posedge clk) begin
		rd_hit = data_req && data_ack && !data_we;
		rd_addr = data_addr;
		#1;
		// data only valid for one cycle, scrambled otherwise
		data_rdata = rd_hit ? {rd_addr[15:0], ~rd_addr[15:0]} : ~data_rdata;
		data_ack = !slow || ($urandom % 3 != 0);
	end
endmodule

/* sim/test_cpu_data_move_decoder.sv */
/*
 * self-checking bench: directed and random move instructions against
 * a register model; every data access is compared in order.
 * assumes the memory model answers reads from the address alone.
 */
`timescale 1ns/1ps

module test_cpu_data_move_decoder;
	logic clk, reset_n, ce, instr_valid, fetch_busy, data_ack, slow;
	logic instr_ready, data_req, data_we, illegal_instr, sr_t_we, exp_ill;
	logic [15:0] instr_word, w;
	logic [31:0] instr_pc, data_rdata, data_addr, data_wdata;
	logic [1:0] data_size;
	logic [31:0] r [16];
	logic [66:0] expq [$];
	logic [66:0] e;
	int n_mismatch, n_compared;

	cdmd_core i_cdmd_core (.clk, .reset_n, .ce, .instr_valid, .instr_word,
		.instr_pc, .instr_ready, .fetch_busy, .data_req, .data_we,
		.data_size, .data_addr, .data_wdata, .data_ack, .data_rdata,
		.illegal_instr, .sr_t_we);
	cdmd_mem_model i_cdmd_mem_model (.clk, .slow, .data_req, .data_we,
		.data_addr, .data_ack, .data_rdata);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] msk(input logic [1:0] s);
		return s == 2'h0 ? 32'hff : (s == 2'h1 ? 32'hffff : 32'hffffffff);
	endfunction

	task automatic check(input string what, input logic [66:0] seen,
			input logic [66:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hold the word until taken; first sample also judges the last one
	task automatic issue(input logic [15:0] wd, input logic ill);
		logic rdy;
		int k;
		instr_word = wd;
		instr_valid = 1'b1;
		k = 0;
		do begin
			@(negedge clk);
			#4;
			rdy = instr_ready;
			if (k == 0) check("illegal", {66'h0, illegal_instr}, {66'h0, exp_ill});
			k++;
			@(posedge clk);
			#1;
		end while (!rdy && k < 60);
		check("taken", {66'h0, rdy}, 67'h1);
		exp_ill = ill;
	endtask

	// register model of the move group, queues the expected access
	task automatic exec(input logic [15:0] wd, input logic ill);
		logic [3:0] n;
		logic [1:0] sz;
		logic [31:0] a, v;
		logic ld, st;
		n = wd[11:8];
		sz = wd[1:0];
		ld = 1'b0;
		st = 1'b0;
		a = 32'h0;
		v = 32'h0;
		instr_pc = $urandom & 32'hfffffffe;
		case (wd[15:12])
			4'he: r[n] = {{24{wd[7]}}, wd[7:0]};
			4'h6: if (sz == 2'h3) begin
				r[n] = r[wd[7:4]];
			end else begin
				ld = 1'b1;
				a = r[wd[7:4]];
				if (wd[2]) r[wd[7:4]] = r[wd[7:4]] + (32'h1 << sz);
			end
			4'h2: begin
				st = 1'b1;
				if (wd[2]) r[n] = r[n] - (32'h1 << sz);
				a = r[n];
				v = r[wd[7:4]];
			end
			4'h1, 4'h5: begin
				ld = wd[14];
				st = !wd[14];
				sz = 2'h2;
				a = r[wd[14] ? wd[7:4] : n] + {26'h0, wd[3:0], 2'h0};
				v = r[wd[7:4]];
			end
			4'h8: begin
				sz = {1'b0, wd[8]};
				ld = wd[10];
				st = !wd[10];
				n = 4'h0;
				a = r[wd[7:4]] + ({28'h0, wd[3:0]} << sz);
				v = r[0];
			end
			4'h9: begin
				ld = 1'b1;
				sz = 2'h1;
				a = instr_pc + {23'h0, wd[7:0], 1'b0};
			end
			4'hd: begin
				ld = 1'b1;
				sz = 2'h2;
				a = {instr_pc[31:2], 2'h0} + {22'h0, wd[7:0], 2'h0};
			end
			4'h0: begin
				st = 1'b1;
				a = r[0] + r[n];
				v = r[wd[7:4]];
			end
			default: ;
		endcase
		a = a & ~((32'h1 << sz) - 32'h1);
		if (ld) begin
			v = {a[15:0], ~a[15:0]};
			if (sz == 2'h0) v = {{24{v[7]}}, v[7:0]};
			if (sz == 2'h1) v = {{16{v[15]}}, v[15:0]};
			r[n] = v;
			v = 32'h0;
		end
		if (ld || st) expq.push_back({st, sz, a, v & msk(sz)});
		issue(wd, ill);
	endtask

	function automatic logic [15:0] pick(input logic [31:0] x);
		logic [2:0] lo;
		lo = {x[18], x[17:16] == 2'h3 ? 2'h2 : x[17:16]};
		case (x[22:19])
			4'h0, 4'h1, 4'h2: return {4'he, x[11:0]};
			4'h3: return {4'h6, x[11:4], 4'h3};
			4'h4, 4'h5: return {4'h2, x[11:5], !x[8] ^ (x[11:9] != x[7:5]), 1'b0, lo};
			4'h6, 4'h7: return {4'h6, x[11:4], 1'b0, lo};
			4'h8: return {4'h1, x[11:0]};
			4'h9: return {4'h5, x[11:0]};
			4'ha: return {5'h10, x[23], 1'b0, x[24], x[7:0]};
			4'hb: return {4'h9, x[11:0]};
			4'hc: return {4'hd, x[11:0]};
			4'hd: return {4'h0, x[11:4], 3'h2, x[24]};
			default: return {4'hf, x[11:0]};
		endcase
	endfunction

	// each accepted access against the oldest queued note
	initial forever begin
		@(negedge clk);
		#4;
		if (data_req === 1'b1 && data_ack === 1'b1) begin
			e = expq.size() > 0 ? expq.pop_front() : 67'h0;
			check("access", {data_we, data_size, data_addr,
				data_we ? data_wdata & msk(data_size) : 32'h0}, e);
		end
	end

	always @(posedge clk) begin
		#1;
		fetch_busy = reset_n && ($urandom % 4 == 0);
	end

	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		void'($urandom(64026));
		{reset_n, instr_valid, fetch_busy, slow, exp_ill} = 5'h0;
		ce = 1'b1;
		instr_word = 16'h0;
		instr_pc = 32'h0;
		foreach (r[i]) r[i] = 32'h0;
		repeat (12) @(posedge clk);
		#1;
		reset_n = 1'b1;
		// load then immediate use of its destination
		exec(16'he240, 1'b0);
		exec(16'h6322, 1'b0);
		exec(16'h2232, 1'b0);
		exec(16'h6007, 1'b1);
		exec(16'hffff, 1'b1);
		for (int i = 0; i < 500; i++) begin
			if (i == 250) slow = 1'b1;
			w = pick($urandom);
			exec(w, w[15:12] == 4'hf);
		end
		instr_valid = 1'b0;
		repeat (30) @(posedge clk);
		check("drain", {66'h0, expq.size() == 0}, 67'h1);
		report_and_stop();
	end
endmodule
